// [rtl/wdt_map.svh]
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// register addresses
`define WDT_ADDR_CLKSEL     16'hFF42
`define WDT_ADDR_MODE       16'hFFF9
`define WDT_ADDR_IRQCTL     16'hFFE8

// reset values
`define WDT_CLKSEL_RST      8'h00
`define WDT_MODE_RST        8'h00
`define WDT_IRQCTL_RST      8'h06

// mode register fields
`define WDT_MODE_RUN_BIT    7
`define WDT_MODE_SEL_BIT    4
`define WDT_MODE_ACT_BIT    3

// irq control register fields
`define WDT_IRQ_REQ_BIT     0
`define WDT_IRQ_MASK_BIT    1
`define WDT_IRQ_PRIO_BIT    2

// count clock select field, bits 2:0 of the clock-select register
`define WDT_SEL_MSB         2
`define WDT_SEL_TOP         3'h7

// count clock exponents: divider is 2^(base + sel), one extra step for sel 7
`define WDT_WD_BASE_EXP     4'h3
`define WDT_IV_BASE_EXP     4'h4

// prescaler and counter widths
`define WDT_PRE_WIDTH       12
`define WDT_CNT_WIDTH       8

`endif

// [rtl/wdt_pkg.sv]
package wdt_pkg;

    typedef logic [7:0] wdt_byte_t;

    // all state of the top module
    typedef struct packed {
        wdt_byte_t clksel;
        logic      run;
        logic      modesel;
        logic      act;
        logic      irq_req;
        logic      irq_mask;
        logic      irq_prio;
        wdt_byte_t rdata;
        logic      nmi;
        logic      sysrst;
        logic      mirq;
        logic      prio;
    } wdt_state_s;

    // register bus request
    typedef struct packed {
        logic [15:0] addr;
        wdt_byte_t   wdata;
        logic        wr;
        logic        rd;
        logic        bit_wr;
        logic [2:0]  bit_idx;
        logic        bit_val;
    } wdt_bus_s;

    // standby and clock status from the cpu
    typedef struct packed {
        logic halt;
        logic stop;
        logic sub_clk;
    } wdt_cpu_s;

endpackage : wdt_pkg

// [rtl/wdt_prescaler.sv]
`timescale 1ns/1ps
`include "wdt_map.svh"

module wdt_prescaler #(
    parameter int WIDTH = `WDT_PRE_WIDTH
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    // control
    input  wire logic             en_i,
    // tick k-1 pulses once every 2^k enabled cycles
    output logic [WIDTH-1:0]      tick_o
);

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } wdt_pre_state_s;

    wdt_pre_state_s state_ff;
    wdt_pre_state_s nxt_state;

    // never cleared by a restart, so the first period may come short
    always_comb begin
        nxt_state = state_ff;
        if (en_i) begin
            nxt_state.cnt = state_ff.cnt + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    for (genvar k = 0; k < WIDTH; k++) begin : g_tick
        assign tick_o[k] = en_i & (&state_ff.cnt[k:0]);
    end

endmodule : wdt_prescaler

// [rtl/wdt_counter.sv]
`timescale 1ns/1ps
`include "wdt_map.svh"

module wdt_counter #(
    parameter int WIDTH = `WDT_CNT_WIDTH
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    // control
    input  wire logic             clr_i,
    input  wire logic             tick_i,
    // status
    output logic [WIDTH-1:0]      cnt_o,
    output logic                  ovf_o
);

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } wdt_cnt_state_s;

    wdt_cnt_state_s state_ff;
    wdt_cnt_state_s nxt_state;

    // clear beats a coincident tick so a restart never overflows at once
    always_comb begin
        nxt_state = state_ff;
        if (clr_i) begin
            nxt_state.cnt = '0;
        end else if (tick_i) begin
            nxt_state.cnt = state_ff.cnt + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign cnt_o = state_ff.cnt;
    assign ovf_o = tick_i & ~clr_i & (&state_ff.cnt);

endmodule : wdt_counter

// [rtl/wdt_top.sv]
// Summary of operation
// - watchdog overflow after 2^11..2^17, 2^19 clocks per select code
// - interval overflow after 2^12..2^18, 2^20 clocks per select code
// - counter clocked by fx/2^3..2^9, 2^11 watchdog, fx/2^4..2^10, 2^12 interval
// - clock-select register at FF42, resets to 00, byte writes only
// - reset clears mode register; it takes bit and byte writes
// - writing 1 to mode bit 7 clears counter and starts counting
// - start bit cannot be cleared by software; only reset clears it
// - mode bit 4 picks watchdog when 1, interval timer when 0
// - mode and action bits set-only; watchdog mode holds until reset
// - watchdog overflow without restart gives reset or nmi per bit 3
// - interval overflow sets the maskable request, counting goes on
// - mask and priority flags govern interval request; default masked, low priority
// - watchdog enabled with request flag set raises nmi regardless
// - first period after restart may be short; prescaler not cleared
// - counting runs in halt standby, stops in stop standby
// - counting halts while the cpu runs from the subsystem clock
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "wdt_map.svh"

module wdt_top #(
    parameter int PRE_WIDTH = `WDT_PRE_WIDTH,
    parameter int CNT_WIDTH = `WDT_CNT_WIDTH
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // register bus
    input  wire logic [15:0] bus_addr_i,
    input  wire logic [7:0]  bus_wdata_i,
    input  wire logic        bus_wr_i,
    input  wire logic        bus_rd_i,
    input  wire logic        bus_bit_wr_i,
    input  wire logic [2:0]  bus_bit_idx_i,
    input  wire logic        bus_bit_val_i,
    output logic [7:0]       bus_rdata_o,
    // cpu status
    input  wire logic        halt_mode_i,
    input  wire logic        stop_mode_i,
    input  wire logic        sub_clk_sel_i,
    // events
    output logic             sys_reset_req_o,
    output logic             nmi_req_o,
    output logic             maskable_irq_o,
    output logic             irq_priority_low_o,
    output logic             counting_o
);

    wdt_pkg::wdt_state_s state_ff;
    wdt_pkg::wdt_state_s nxt_state;
    wdt_pkg::wdt_bus_s   bus;
    wdt_pkg::wdt_cpu_s   cpu;

    logic [PRE_WIDTH-1:0] tick_vec;
    logic [CNT_WIDTH-1:0] cnt;
    logic                 ovf;
    logic                 count_en;
    logic                 restart;
    logic [3:0]           div_exp;
    logic                 sel_tick;
    logic [2:0]           sel;
    logic                 hit_clksel;
    logic                 hit_mode;
    logic                 hit_irqctl;
    logic [7:0]           wr_mask;
    logic [7:0]           wr_val;

    assign bus = '{addr: bus_addr_i, wdata: bus_wdata_i, wr: bus_wr_i, rd: bus_rd_i,
                   bit_wr: bus_bit_wr_i, bit_idx: bus_bit_idx_i, bit_val: bus_bit_val_i};
    assign cpu = '{halt: halt_mode_i, stop: stop_mode_i, sub_clk: sub_clk_sel_i};

    assign hit_clksel = (bus.addr == `WDT_ADDR_CLKSEL);
    assign hit_mode   = (bus.addr == `WDT_ADDR_MODE);
    assign hit_irqctl = (bus.addr == `WDT_ADDR_IRQCTL);

    // byte write and bit write reduced to one mask and value
    always_comb begin
        wr_mask = 8'h00;
        wr_val  = 8'h00;
        if (bus.wr) begin
            wr_mask = 8'hFF;
            wr_val  = bus.wdata;
        end else if (bus.bit_wr) begin
            wr_mask = 8'h01 << bus.bit_idx;
            wr_val  = {7'h00, bus.bit_val} << bus.bit_idx;
        end
    end

    assign restart = hit_mode & wr_mask[`WDT_MODE_RUN_BIT] & wr_val[`WDT_MODE_RUN_BIT];

    // halt keeps counting; stop and subsystem clock freeze prescaler and counter
    assign count_en = state_ff.run & ~cpu.stop & ~cpu.sub_clk;

    // count clock exponent; code 7 skips one power of two
    assign sel = state_ff.clksel[`WDT_SEL_MSB:0];
    always_comb begin
        div_exp = (state_ff.modesel ? `WDT_WD_BASE_EXP : `WDT_IV_BASE_EXP) + {1'b0, sel};
        if (sel == `WDT_SEL_TOP) begin
            div_exp = div_exp + 4'h1;
        end
    end
    assign sel_tick = tick_vec[div_exp - 4'h1];

    wdt_prescaler #(
        .WIDTH (PRE_WIDTH)
    ) u_prescaler (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .en_i      (count_en),
        .tick_o    (tick_vec)
    );

    wdt_counter #(
        .WIDTH (CNT_WIDTH)
    ) u_counter (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .clr_i     (restart),
        .tick_i    (sel_tick),
        .cnt_o     (cnt),
        .ovf_o     (ovf)
    );

    always_comb begin
        nxt_state        = state_ff;
        nxt_state.rdata  = 8'h00;
        nxt_state.nmi    = 1'b0;
        nxt_state.sysrst = 1'b0;

        // whole-byte writes only; bit writes to this register are dropped
        if (hit_clksel && bus.wr) begin
            nxt_state.clksel = bus.wdata;
        end

        // set-only bits, a written 0 is ignored
        if (hit_mode) begin
            nxt_state.run     = state_ff.run | (wr_mask[`WDT_MODE_RUN_BIT] &
                                                wr_val[`WDT_MODE_RUN_BIT]);
            nxt_state.modesel = state_ff.modesel | (wr_mask[`WDT_MODE_SEL_BIT] &
                                                    wr_val[`WDT_MODE_SEL_BIT]);
            nxt_state.act     = state_ff.act | (wr_mask[`WDT_MODE_ACT_BIT] &
                                                wr_val[`WDT_MODE_ACT_BIT]);
        end

        if (hit_irqctl) begin
            if (wr_mask[`WDT_IRQ_REQ_BIT]) begin
                nxt_state.irq_req = wr_val[`WDT_IRQ_REQ_BIT];
            end
            if (wr_mask[`WDT_IRQ_MASK_BIT]) begin
                nxt_state.irq_mask = wr_val[`WDT_IRQ_MASK_BIT];
            end
            if (wr_mask[`WDT_IRQ_PRIO_BIT]) begin
                nxt_state.irq_prio = wr_val[`WDT_IRQ_PRIO_BIT];
            end
        end

        // overflow handling, applied after software so a set beats a clear
        if (ovf) begin
            if (state_ff.modesel) begin
                if (state_ff.act) begin
                    nxt_state.sysrst = 1'b1;
                end else begin
                    nxt_state.nmi = 1'b1;
                end
            end else begin
                nxt_state.irq_req = 1'b1;
            end
        end

        // entering watchdog mode with a pending request fires the nmi
        if (!state_ff.modesel && nxt_state.modesel && state_ff.irq_req) begin
            nxt_state.nmi = 1'b1;
        end

        // request only reaches the cpu in interval mode, gated by the mask
        nxt_state.mirq = nxt_state.irq_req & ~nxt_state.irq_mask & ~nxt_state.modesel;
        nxt_state.prio = nxt_state.irq_prio;

        if (bus.rd) begin
            if (hit_clksel) begin
                nxt_state.rdata = state_ff.clksel;
            end else if (hit_mode) begin
                nxt_state.rdata = {state_ff.run, 2'b00, state_ff.modesel, state_ff.act, 3'b000};
            end else if (hit_irqctl) begin
                nxt_state.rdata = {5'h00, state_ff.irq_prio, state_ff.irq_mask,
                                   state_ff.irq_req};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_ff          <= '0;
            state_ff.clksel   <= `WDT_CLKSEL_RST;
            state_ff.run      <= 1'(`WDT_MODE_RST >> `WDT_MODE_RUN_BIT);
            state_ff.modesel  <= 1'(`WDT_MODE_RST >> `WDT_MODE_SEL_BIT);
            state_ff.act      <= 1'(`WDT_MODE_RST >> `WDT_MODE_ACT_BIT);
            state_ff.irq_req  <= 1'(`WDT_IRQCTL_RST >> `WDT_IRQ_REQ_BIT);
            state_ff.irq_mask <= 1'(`WDT_IRQCTL_RST >> `WDT_IRQ_MASK_BIT);
            state_ff.irq_prio <= 1'(`WDT_IRQCTL_RST >> `WDT_IRQ_PRIO_BIT);
            state_ff.prio     <= 1'(`WDT_IRQCTL_RST >> `WDT_IRQ_PRIO_BIT);
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign bus_rdata_o        = state_ff.rdata;
    assign sys_reset_req_o    = state_ff.sysrst;
    assign nmi_req_o          = state_ff.nmi;
    assign maskable_irq_o     = state_ff.mirq;
    assign irq_priority_low_o = state_ff.prio;
    assign counting_o         = state_ff.run;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_restart_clears: assert property (
        restart |=> (cnt == '0))
        else $error("restart did not clear the counter");

    a_run_sticky: assert property (
        state_ff.run |=> state_ff.run)
        else $error("run bit fell without reset");

    a_mode_sticky: assert property (
        (state_ff.modesel && state_ff.act) |=> (state_ff.modesel && state_ff.act))
        else $error("mode or action bit cleared by software");

    a_clksel_bitwr: assert property (
        (bus.bit_wr && hit_clksel) |=> $stable(state_ff.clksel))
        else $error("bit write altered clock select");

    a_wd_reset: assert property (
        (ovf && state_ff.modesel && state_ff.act) |=> (sys_reset_req_o && !nmi_req_o))
        else $error("watchdog overflow did not request reset");

    a_wd_nmi: assert property (
        (ovf && state_ff.modesel && !state_ff.act) |=> (nmi_req_o && !sys_reset_req_o))
        else $error("watchdog overflow did not raise nmi");

    a_iv_request: assert property (
        (ovf && !state_ff.modesel) |=> (state_ff.irq_req && !nmi_req_o && !sys_reset_req_o))
        else $error("interval overflow did not set request");

    a_pending_nmi: assert property (
        (!state_ff.modesel && state_ff.irq_req && hit_mode && bus.wr &&
         bus.wdata[`WDT_MODE_SEL_BIT]) |=> nmi_req_o)
        else $error("watchdog entry with pending request gave no nmi");

    a_stop_freezes: assert property (
        (cpu.stop && !restart) |=> $stable(cnt))
        else $error("counter moved in stop standby");

    a_subclk_freezes: assert property (
        (cpu.sub_clk && !restart) |=> $stable(cnt))
        else $error("counter moved on subsystem clock");

    a_top_code_exp: assert property (
        (state_ff.modesel && sel == 3'h7) |-> (div_exp == 4'hB))
        else $error("watchdog top code divider wrong");

    a_mask_gates: assert property (
        (state_ff.irq_mask || state_ff.modesel) |-> !maskable_irq_o)
        else $error("masked request reached the cpu");

endmodule : wdt_top

// [verification/wdt_top_tb_top.sv]
`timescale 1ns/1ps
`include "wdt_map.svh"

module wdt_top_tb_top;
    logic        clk_i;
    logic        sys_rst_i;
    logic [15:0] bus_addr_i;
    logic [7:0]  bus_wdata_i;
    logic        bus_wr_i;
    logic        bus_rd_i;
    logic        bus_bit_wr_i;
    logic [2:0]  bus_bit_idx_i;
    logic        bus_bit_val_i;
    logic [7:0]  bus_rdata_o;
    logic        halt_mode_i;
    logic        stop_mode_i;
    logic        sub_clk_sel_i;
    logic        sys_reset_req_o;
    logic        nmi_req_o;
    logic        maskable_irq_o;
    logic        irq_priority_low_o;
    logic        counting_o;
    int          n_fail;
    int          num_checks;
    int          cyc;
    int          tev;
    int          t1;
    int          k;
    bit          hit;

    wdt_top dut (
        .clk_i              (clk_i),
        .sys_rst_i          (sys_rst_i),
        .bus_addr_i         (bus_addr_i),
        .bus_wdata_i        (bus_wdata_i),
        .bus_wr_i           (bus_wr_i),
        .bus_rd_i           (bus_rd_i),
        .bus_bit_wr_i       (bus_bit_wr_i),
        .bus_bit_idx_i      (bus_bit_idx_i),
        .bus_bit_val_i      (bus_bit_val_i),
        .bus_rdata_o        (bus_rdata_o),
        .halt_mode_i        (halt_mode_i),
        .stop_mode_i        (stop_mode_i),
        .sub_clk_sel_i      (sub_clk_sel_i),
        .sys_reset_req_o    (sys_reset_req_o),
        .nmi_req_o          (nmi_req_o),
        .maskable_irq_o     (maskable_irq_o),
        .irq_priority_low_o (irq_priority_low_o),
        .counting_o         (counting_o)
    );

    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR at %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus_wr_i    <= 1'b1;
        bus_addr_i  <= a;
        bus_wdata_i <= d;
        @(posedge clk_i);
        bus_wr_i    <= 1'b0;
    endtask : wr

    task automatic bwr(input logic [15:0] a, input logic [2:0] i, input logic v);
        @(posedge clk_i);
        bus_bit_wr_i  <= 1'b1;
        bus_addr_i    <= a;
        bus_bit_idx_i <= i;
        bus_bit_val_i <= v;
        @(posedge clk_i);
        bus_bit_wr_i  <= 1'b0;
    endtask : bwr

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        bus_rd_i   <= 1'b1;
        bus_addr_i <= a;
        @(posedge clk_i);
        bus_rd_i   <= 1'b0;
        #1;
        chk(32'(bus_rdata_o), 32'(exp));
    endtask : rd

    function automatic logic pick(input int w);
        return (w == 0) ? nmi_req_o : (w == 1) ? sys_reset_req_o : maskable_irq_o;
    endfunction : pick

    // rising edge only, so a request left standing is not mistaken for a new one
    task automatic wait_ev(input int w, input int lim, output bit h);
        logic prev;
        prev = pick(w);
        h = 1'b0;
        for (int i = 0; i < lim && !h; i++) begin
            @(posedge clk_i);
            #1;
            if (pick(w) === 1'b1 && prev !== 1'b1) h = 1'b1;
            prev = pick(w);
        end
        tev = cyc;
    endtask : wait_ev

    task automatic need(input int w, input int lim);
        wait_ev(w, lim, hit);
        chk(32'(hit), 32'h1);
        if (!hit) conclude();
    endtask : need

    task automatic do_reset();
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
    endtask : do_reset

    initial begin
        clk_i = 1'b0; sys_rst_i = 1'b1; bus_addr_i = 16'h0000; bus_wdata_i = 8'h00;
        bus_wr_i = 1'b0; bus_rd_i = 1'b0; bus_bit_wr_i = 1'b0; bus_bit_idx_i = 3'h0;
        bus_bit_val_i = 1'b0; halt_mode_i = 1'b0; stop_mode_i = 1'b0; sub_clk_sel_i = 1'b0;
        n_fail = 0; num_checks = 0; cyc = 0;
        do_reset();
        rd(`WDT_ADDR_CLKSEL, 8'h00);
        rd(`WDT_ADDR_MODE, 8'h00);
        rd(`WDT_ADDR_IRQCTL, 8'h06);
        rd(16'h1234, 8'h00);
        chk(32'(counting_o), 32'h0);
        bwr(`WDT_ADDR_CLKSEL, 3'h0, 1'b1);
        rd(`WDT_ADDR_CLKSEL, 8'h00);
        wr(`WDT_ADDR_CLKSEL, 8'h01);
        rd(`WDT_ADDR_CLKSEL, 8'h01);
        wr(`WDT_ADDR_CLKSEL, 8'h00);
        $display("test registers done");
        // interval mode started through a single-bit write
        bwr(`WDT_ADDR_MODE, 3'h7, 1'b1);
        #1;
        chk(32'(counting_o), 32'h1);
        wr(`WDT_ADDR_MODE, 8'h00);
        rd(`WDT_ADDR_MODE, 8'h80);
        chk(32'(counting_o), 32'h1);
        wr(`WDT_ADDR_IRQCTL, 8'h00);
        #1;
        chk(32'(irq_priority_low_o), 32'h0);
        // plain, halt, stop, subsystem clock: only the last two freeze the count
        for (k = 0; k < 4; k++) begin
            wr(`WDT_ADDR_IRQCTL, 8'h00);
            need(2, 4200);
            t1 = tev;
            wr(`WDT_ADDR_IRQCTL, 8'h00);
            halt_mode_i   <= (k == 1);
            stop_mode_i   <= (k == 2);
            sub_clk_sel_i <= (k == 3);
            repeat (100) @(posedge clk_i);
            halt_mode_i   <= 1'b0;
            stop_mode_i   <= 1'b0;
            sub_clk_sel_i <= 1'b0;
            need(2, 4300);
            chk(32'(tev - t1), (k >= 2) ? 32'd4196 : 32'd4096);
        end
        wr(`WDT_ADDR_IRQCTL, 8'h02);
        wait_ev(2, 4200, hit);
        chk(32'(maskable_irq_o), 32'h0);
        rd(`WDT_ADDR_IRQCTL, 8'h03);
        $display("test interval done");
        // watchdog, select 1, system reset action
        do_reset();
        wr(`WDT_ADDR_CLKSEL, 8'h01);
        wr(`WDT_ADDR_MODE, 8'h98);
        for (k = 0; k < 3; k++) begin
            wait_ev(1, 3000, hit);
            chk(32'(hit), 32'h0);
            bwr(`WDT_ADDR_MODE, 3'h7, 1'b1);
        end
        #1;
        t1 = cyc;
        wr(`WDT_ADDR_MODE, 8'h80);
        rd(`WDT_ADDR_MODE, 8'h98);
        need(1, 4200);
        // restart does not clear the prescaler, so up to one tick short
        chk(32'((tev - t1) >= 4060 && (tev - t1) <= 4100), 32'h1);
        $display("test watchdog reset done");
        // watchdog, select 0, interrupt action
        do_reset();
        wr(`WDT_ADDR_MODE, 8'h90);
        need(0, 2200);
        t1 = tev;
        need(0, 2200);
        chk(32'(tev - t1), 32'd2048);
        $display("test watchdog nmi done");
        // entering watchdog with request pending gives nmi despite reset action
        do_reset();
        wr(`WDT_ADDR_IRQCTL, 8'h01);
        wr(`WDT_ADDR_MODE, 8'h98);
        // the pulse stands for one cycle only, so look at it right away
        #1;
        chk(32'(nmi_req_o), 32'h1);
        chk(32'(sys_reset_req_o), 32'h0);
        $display("test pending request done");
        conclude();
    end
endmodule : wdt_top_tb_top
